// [flash_cmd_pkg.sv]
// Shared constants and carriers for the flash command interpreter.
package flash_cmd_pkg;

  // Opcodes that wait for the suspend latency.
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0B;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO4   = 8'hEC;
  localparam logic [7:0] OP_QUAD_DTR   = 8'hED;
  localparam logic [7:0] OP_QUAD_DTR4  = 8'hEE;
  localparam logic [7:0] OP_FAST4      = 8'h0C;
  localparam logic [7:0] OP_DUAL_IO4   = 8'hBC;
  localparam logic [7:0] OP_DUAL_OUT4  = 8'h3C;
  localparam logic [7:0] OP_PARAM_RD   = 8'h5A;
  localparam logic [7:0] OP_ID_READ    = 8'h9F;
  localparam logic [7:0] OP_QUAD_ID    = 8'hAF;
  localparam logic [7:0] OP_BURST_LEN  = 8'hC0;
  localparam logic [7:0] OP_ENTER_OTP  = 8'hB1;
  localparam logic [7:0] OP_EXIT_OTP   = 8'hC1;
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_RESUME     = 8'h30;
  localparam logic [7:0] OP_LOCK_RD    = 8'h2D;
  localparam logic [7:0] OP_SPB_RD     = 8'hE2;
  localparam logic [7:0] OP_FBR_RD     = 8'h16;
  localparam logic [7:0] OP_DPB_RD     = 8'hE0;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
  localparam logic [7:0] OP_EXIT_QUAD  = 8'hF5;
  localparam logic [7:0] OP_MFR_ID     = 8'h90;
  // Opcodes accepted at any time while suspended.
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_RD  = 8'h05;
  localparam logic [7:0] OP_CONFIG_RD  = 8'h15;
  localparam logic [7:0] OP_SECUR_RD   = 8'h2B;
  localparam logic [7:0] OP_SIGN_RD    = 8'hAB;
  localparam logic [7:0] OP_RESET_ARM  = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  localparam logic [7:0] OP_NOP        = 8'h00;

  // Security register suspend bit positions.
  localparam int SEC_PROG_SUSP_BIT  = 2;
  localparam int SEC_ERASE_SUSP_BIT = 3;

  // Parameter-table read framing, in bytes.
  localparam int PARAM_ADDR_BYTES  = 3;
  localparam int PARAM_DUMMY_BYTES = 1;

  // Serial clocks per opcode.
  localparam int SINGLE_OP_CLOCKS = 8;
  localparam int QUAD_OP_CLOCKS   = 2;

  // Timing, in ns, and the clock period.
  localparam int CLK_PERIOD_NS            = 10;
  localparam int SUSPEND_LATENCY_NS       = 20000;
  localparam int RESET_RECOVERY_IDLE_NS   = 20000;
  localparam int RESET_RECOVERY_BUSY_NS   = 40000;
  localparam int SUSPEND_LATENCY_CYC      = (SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_IDLE_CYC           = (RESET_RECOVERY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_BUSY_CYC           = (RESET_RECOVERY_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Status bits seen by the host.
  typedef struct packed {
    logic write_enable_latch;
    logic write_in_progress;
    logic program_suspended_flag;
    logic erase_suspended_flag;
  } flag_set_t;

  // Operation engine handshake.
  typedef enum logic [1:0] {OPKIND_NONE, OPKIND_PROGRAM, OPKIND_ERASE} opkind_t;

endpackage

// [flash_suspend_resume_reset.sv]
// Command interpreter for suspend, resume, no-operation, reset and parameter-table reads.
`timescale 1ns/1ns
`default_nettype none
module flash_suspend_resume_reset
  import flash_cmd_pkg::*;
#(
  parameter int SUSP_CYC    = SUSPEND_LATENCY_CYC,
  parameter int RST_IDLE    = RESET_IDLE_CYC,
  parameter int RST_BUSY    = RESET_BUSY_CYC,
  parameter int TABLE_DEPTH = 256
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Serial link pins
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] sio_in,
  output logic      [3:0] sio_out,
  output logic      [3:0] sio_oe,
  // Mode and operation engine
  input  wire logic       enhance_mode,
  input  wire logic       suspend_done,
  input  wire logic       op_done,
  input  wire logic [7:0] table_data,
  output logic      [7:0] table_addr,
  output logic            op_resume,
  output logic            op_abort,
  output logic            cmd_accept,
  output logic            cmd_reject,
  output logic      [7:0] cmd_code,
  output logic            quad_command_mode,
  output logic            busy_recovery,
  output logic      [7:0] security_reg,
  output flag_set_t       flags
);

  // The latency and recovery counters are 16 bits wide, the table address 8 bits.
  if (TABLE_DEPTH < 2 || TABLE_DEPTH > 256 || SUSP_CYC < 1 || SUSP_CYC > 65535
      || RST_IDLE < 1 || RST_IDLE > 65535 || RST_BUSY < 1 || RST_BUSY > 65535) begin : g_param_check
    $error("flash_suspend_resume_reset: bad parameter");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock edge detection.
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic       sclk_d;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Idle pin levels, chip select high and link clock low, so no false edge follows reset.
      sync1  <= 6'h20;
      sync2  <= 6'h20;
      sclk_d <= 1'b0;
    end else begin
      sync1  <= {cs_n, sclk, sio_in};
      sync2  <= sync1;
      sclk_d <= sync2[4];
    end
  end
  logic       cs_low;
  logic       rise;
  logic       fall;
  logic [3:0] io_s;
  assign cs_low = !sync2[5];
  assign io_s   = sync2[3:0];
  assign rise   = cs_low && sync2[4] && !sclk_d;
  assign fall   = cs_low && !sync2[4] && sclk_d;

  function automatic logic needs_latency(input logic [7:0] op);
    unique case (op)
      OP_READ, OP_FAST_READ, OP_DUAL_IO, OP_DUAL_OUT, OP_QUAD_IO, OP_QUAD_OUT,
      OP_QUAD_IO4, OP_QUAD_DTR, OP_QUAD_DTR4, OP_FAST4, OP_DUAL_IO4, OP_DUAL_OUT4,
      OP_PARAM_RD, OP_ID_READ, OP_QUAD_ID, OP_BURST_LEN, OP_ENTER_OTP, OP_EXIT_OTP,
      OP_WR_ENABLE, OP_RESUME, OP_LOCK_RD, OP_SPB_RD, OP_FBR_RD, OP_DPB_RD,
      OP_ENTER_QUAD, OP_EXIT_QUAD, OP_MFR_ID: needs_latency = 1'b1;
      default:                                needs_latency = 1'b0;
    endcase
  endfunction

  function automatic logic any_time(input logic [7:0] op);
    unique case (op)
      OP_WR_DISABLE, OP_STATUS_RD, OP_CONFIG_RD, OP_SECUR_RD, OP_SIGN_RD,
      OP_RESET_ARM, OP_RESET_EXEC, OP_NOP: any_time = 1'b1;
      default:                             any_time = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Command state.
  typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} phase_t;
  typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_SUSP_WAIT, OP_SUSP} opstate_t;

  phase_t      phase,      next_phase;
  opstate_t    opst,       next_opst;
  opkind_t     kind,       next_kind;
  logic [7:0]  shreg,      next_shreg;
  logic [2:0]  bitcnt,     next_bitcnt;
  logic [1:0]  bytecnt,    next_bytecnt;
  logic [7:0]  outbyte,    next_outbyte;
  logic        armed,      next_armed;
  logic        quad,       next_quad;
  logic [15:0] latcnt,     next_latcnt;
  logic [15:0] reccnt,     next_reccnt;
  logic        rec_busy,   next_rec_busy;
  logic [7:0]  taddr,      next_taddr;
  flag_set_t   fl,         next_fl;
  logic        acc_p,      next_acc_p;
  logic        rej_p,      next_rej_p;
  logic        res_p,      next_res_p;
  logic        abt_p,      next_abt_p;
  logic [7:0]  code,       next_code;
  logic [3:0]  so,         next_so;
  logic        so_en,      next_so_en;

  logic [7:0] op_full;
  logic       last_bit;
  logic       suspended;
  assign op_full   = quad ? {shreg[3:0], io_s} : {shreg[6:0], io_s[0]};
  assign last_bit  = quad ? (bitcnt == 3'(QUAD_OP_CLOCKS - 1))
                          : (bitcnt == 3'(SINGLE_OP_CLOCKS - 1));
  assign suspended = (opst == OP_SUSP_WAIT) || (opst == OP_SUSP);

  always_comb begin
    next_phase   = phase;
    next_opst    = opst;
    next_kind    = kind;
    next_shreg   = shreg;
    next_bitcnt  = bitcnt;
    next_bytecnt = bytecnt;
    next_outbyte = outbyte;
    next_armed   = armed;
    next_quad    = quad;
    next_latcnt  = latcnt;
    next_reccnt  = (reccnt != 16'h0000) ? reccnt - 16'h0001 : reccnt;
    next_taddr   = taddr;
    next_fl      = fl;
    next_acc_p   = 1'b0;
    next_rej_p   = 1'b0;
    next_res_p   = 1'b0;
    next_abt_p   = 1'b0;
    next_code    = code;
    next_so      = so;
    next_so_en   = so_en;

    // Operation engine tracking.
    if (opst == OP_SUSP_WAIT && latcnt != 16'h0000) begin
      next_latcnt = latcnt - 16'h0001;
    end
    if ((opst == OP_RUN || opst == OP_IDLE) && suspend_done) begin
      next_opst   = OP_SUSP_WAIT;
      next_latcnt = 16'(SUSP_CYC);
      next_kind   = (kind == OPKIND_ERASE) ? OPKIND_ERASE : OPKIND_PROGRAM;
      next_fl.write_enable_latch = 1'b0;
      next_fl.write_in_progress  = 1'b0;
      next_fl.program_suspended_flag = (kind != OPKIND_ERASE);
      next_fl.erase_suspended_flag   = (kind == OPKIND_ERASE);
    end
    if (opst == OP_SUSP_WAIT && latcnt == 16'h0000) begin
      next_opst = OP_SUSP;
    end
    if (opst == OP_RUN && op_done) begin
      next_opst = OP_IDLE;
      next_kind = OPKIND_NONE;
      next_fl.write_enable_latch = 1'b0;
      next_fl.write_in_progress  = 1'b0;
    end

    if (!cs_low) begin
      // Chip select high frames every command and stops output.
      next_phase  = ST_OPCODE;
      next_bitcnt = 3'h0;
      next_so_en  = 1'b0;
    end else if (rise) begin
      unique case (phase)
        ST_OPCODE: begin
          next_shreg  = op_full;
          next_bitcnt = bitcnt + 3'h1;
          if (last_bit) begin
            next_bitcnt = 3'h0;
            next_code   = op_full;
            next_phase  = ST_IGNORE;
            if (reccnt != 16'h0000) begin
              next_rej_p = 1'b1;
            end else if (suspended && !any_time(op_full)
                         && !(needs_latency(op_full) && opst == OP_SUSP)) begin
              next_rej_p = 1'b1;
            end else begin
              next_acc_p = 1'b1;
              next_armed = (op_full == OP_RESET_ARM);
              unique case (op_full)
                OP_RESET_EXEC: begin
                  if (armed) begin
                    next_abt_p  = (opst != OP_IDLE);
                    next_reccnt = (opst == OP_RUN) ? 16'(RST_BUSY)
                                                   : 16'(RST_IDLE);
                    next_opst   = OP_IDLE;
                    next_kind   = OPKIND_NONE;
                    next_fl     = '0;
                    next_quad   = 1'b0;
                  end
                end
                OP_RESUME: begin
                  if (suspended && !enhance_mode) begin
                    next_opst = OP_RUN;
                    next_res_p = 1'b1;
                    next_fl.write_enable_latch     = 1'b1;
                    next_fl.write_in_progress      = 1'b1;
                    next_fl.program_suspended_flag = 1'b0;
                    next_fl.erase_suspended_flag   = 1'b0;
                  end
                end
                OP_WR_ENABLE:  next_fl.write_enable_latch = 1'b1;
                OP_WR_DISABLE: next_fl.write_enable_latch = 1'b0;
                OP_ENTER_QUAD: next_quad = 1'b1;
                OP_EXIT_QUAD:  next_quad = 1'b0;
                OP_PARAM_RD: begin
                  next_phase   = ST_ADDR;
                  next_bytecnt = 2'h0;
                end
                default: ;
              endcase
            end
          end
        end
        ST_ADDR, ST_DUMMY: begin
          // Address and dummy bytes arrive one bit per clock on the input line.
          next_shreg  = {shreg[6:0], io_s[0]};
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            next_bitcnt  = 3'h0;
            next_bytecnt = bytecnt + 2'h1;
            if (phase == ST_DUMMY) begin
              next_phase = ST_DATA;
            end else if (bytecnt == 2'(PARAM_ADDR_BYTES - 1)) begin
              next_taddr   = {shreg[6:0], io_s[0]};
              next_bytecnt = 2'h0;
              next_phase   = ST_DUMMY;
            end
          end
        end
        ST_DATA: ;
        ST_IGNORE: ;
      endcase
    end else if (fall && phase == ST_DATA) begin
      // Output changes on the falling edge so the host samples a settled bit.
      next_so_en  = 1'b1;
      next_bitcnt = bitcnt + 3'h1;
      if (bitcnt == 3'h0) begin
        next_so[1]   = table_data[7];
        next_outbyte = {table_data[6:0], 1'b0};
      end else begin
        next_so[1]   = outbyte[7];
        next_outbyte = {outbyte[6:0], 1'b0};
      end
      if (bitcnt == 3'h7) begin
        next_taddr = (taddr == 8'(TABLE_DEPTH - 1)) ? 8'h00 : taddr + 8'h01;
      end
    end
    next_rec_busy = (next_reccnt != 16'h0000);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase   <= ST_OPCODE;
      opst    <= OP_IDLE;
      kind    <= OPKIND_NONE;
      shreg   <= 8'h00;
      bitcnt  <= 3'h0;
      bytecnt <= 2'h0;
      outbyte <= 8'h00;
      armed   <= 1'b0;
      quad    <= 1'b0;
      latcnt  <= 16'h0000;
      reccnt  <= 16'h0000;
      rec_busy <= 1'b0;
      taddr   <= 8'h00;
      fl      <= '0;
      acc_p   <= 1'b0;
      rej_p   <= 1'b0;
      res_p   <= 1'b0;
      abt_p   <= 1'b0;
      code    <= 8'h00;
      so      <= 4'h0;
      so_en   <= 1'b0;
    end else begin
      phase   <= next_phase;
      opst    <= next_opst;
      kind    <= next_kind;
      shreg   <= next_shreg;
      bitcnt  <= next_bitcnt;
      bytecnt <= next_bytecnt;
      outbyte <= next_outbyte;
      armed   <= next_armed;
      quad    <= next_quad;
      latcnt  <= next_latcnt;
      reccnt  <= next_reccnt;
      rec_busy <= next_rec_busy;
      taddr   <= next_taddr;
      fl      <= next_fl;
      acc_p   <= next_acc_p;
      rej_p   <= next_rej_p;
      res_p   <= next_res_p;
      abt_p   <= next_abt_p;
      code    <= next_code;
      so      <= next_so;
      so_en   <= next_so_en;
    end
  end

  // Without a program engine in this block, a running operation is assumed to be
  // the suspended one; kind is fixed as program here.
  assign table_addr        = taddr;
  assign op_resume         = res_p;
  assign op_abort          = abt_p;
  assign cmd_accept        = acc_p;
  assign cmd_reject        = rej_p;
  assign cmd_code          = code;
  assign quad_command_mode = quad;
  assign busy_recovery     = rec_busy;
  assign sio_out           = so;
  assign sio_oe            = {2'b00, so_en, 1'b0};
  assign flags             = fl;
  always_comb begin
    security_reg = 8'h00;
    security_reg[SEC_PROG_SUSP_BIT]  = fl.program_suspended_flag;
    security_reg[SEC_ERASE_SUSP_BIT] = fl.erase_suspended_flag;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  resume_sets_flags_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(res_p) |-> fl.write_enable_latch && fl.write_in_progress && !fl.program_suspended_flag)
    else $error("resume flags wrong");
  done_clears_a: assert property (@(posedge ref_clk) disable iff (rst)
    (opst == OP_RUN && op_done && !(cs_low && rise)) |=> !fl.write_in_progress)
    else $error("done did not clear busy");
  reset_needs_arm_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(busy_recovery) |-> $past(armed, 2) || $past(armed))
    else $error("reset without arm");
  recovery_rejects_a: assert property (@(posedge ref_clk) disable iff (rst)
    busy_recovery && cs_low && rise && phase == ST_OPCODE && last_bit |=> rej_p && !acc_p)
    else $error("command during recovery");
  enhance_blocks_a: assert property (@(posedge ref_clk) disable iff (rst)
    res_p |-> !$past(enhance_mode))
    else $error("resume during enhance mode");
  csn_stops_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    !cs_low |=> !so_en)
    else $error("output after chip select");
  security_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
    security_reg[3:2] == {fl.erase_suspended_flag, fl.program_suspended_flag})
    else $error("security bits wrong");
  reset_defaults_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(busy_recovery) |-> flags == '0 && !quad)
    else $error("reset left state");
  latency_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    acc_p && opst == OP_SUSP_WAIT && $past(opst) == OP_SUSP_WAIT |-> any_time(code))
    else $error("latency command too early");

endmodule
`default_nettype wire

// [flash_host_model.sv]
// Host-side serial controller model that frames opcodes and reads table bytes.
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Device pins
  input  wire logic [3:0] sio_out,
  output logic            cs_n,
  output logic            sclk,
  output logic      [3:0] host_io
);
  // The link clock stands still low between frames.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    host_io = 4'h0;
  end

  task automatic half();
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic open_frame();
    @(posedge ref_clk);
    cs_n <= 1'b0;
    half();
  endtask

  // Released lines flip so that a stale level is never taken for data.
  task automatic close_frame();
    half();
    cs_n <= 1'b1;
    host_io <= ~host_io;
    half();
  endtask

  // One byte msb first; single-line mode puts noise on the upper lines.
  task automatic shift(input logic [7:0] b, input bit quad, output logic [7:0] r);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      host_io <= quad ? (i == 0 ? b[7:4] : b[3:0]) : {3'($urandom), b[7 - i]};
      half();
      sclk <= 1'b1;
      r = {r[6:0], sio_out[1]};
      half();
      sclk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the suspend, resume, reset and table-read interpreter.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import flash_cmd_pkg::*;
  localparam int S_CYC  = 300;
  localparam int R_IDLE = 200;
  localparam int R_BUSY = 400;
  // Stand-in for the self-timed program time that the host waits after a resume.
  localparam int T_PROG = 100;
  // Recovery runs from the opcode's last rise, about this many cycles before update() runs.
  localparam int REC_TAIL = 24;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       enhance_mode = 1'b0;
  logic       suspend_done = 1'b0;
  logic       op_done = 1'b0;
  logic       cs_n, sclk, op_resume, op_abort, cmd_accept, cmd_reject;
  logic       quad_command_mode, busy_recovery;
  logic [3:0] host_io, sio_in, sio_out, sio_oe;
  logic [7:0] table_data, table_addr, cmd_code, security_reg;
  flag_set_t  flags;
  int n_errors = 0, checked = 0, cyc = 0, n_acc = 0, n_rej = 0, n_res = 0, n_abt = 0;
  int m_rec = 0, m_st = 0, exp_res = 0, exp_abt = 0, rec_cnt = 0;
  bit m_susp, m_wel, m_wip, m_arm, m_quad;
  logic [7:0] lat[] = '{8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'hEC, 8'hED, 8'hEE,
    8'h0C, 8'hBC, 8'h3C, 8'h5A, 8'h9F, 8'hAF, 8'hC0, 8'hB1, 8'hC1, 8'h06, 8'h30, 8'h2D,
    8'hE2, 8'h16, 8'hE0, 8'h35, 8'hF5, 8'h90};
  logic [7:0] nolat[] = '{8'h04, 8'h05, 8'h15, 8'h2B, 8'hAB, 8'h66, 8'h00, 8'h99};

  always #5 ref_clk = ~ref_clk;
  assign sio_in = (sio_oe & sio_out) | (~sio_oe & host_io);
  assign table_data = table_addr ^ 8'hC3;

  flash_suspend_resume_reset #(.SUSP_CYC(S_CYC), .RST_IDLE(R_IDLE), .RST_BUSY(R_BUSY)) dut (
    .ref_clk, .rst, .cs_n, .sclk, .sio_in, .sio_out, .sio_oe, .enhance_mode, .suspend_done,
    .op_done, .table_data, .table_addr, .op_resume, .op_abort, .cmd_accept, .cmd_reject,
    .cmd_code, .quad_command_mode, .busy_recovery, .security_reg, .flags);
  flash_host_model host (.ref_clk, .sio_out, .cs_n, .sclk, .host_io);

  always @(posedge ref_clk) begin
    cyc++;
    n_acc += (cmd_accept === 1'b1);
    n_rej += (cmd_reject === 1'b1);
    n_res += (op_resume === 1'b1);
    n_abt += (op_abort === 1'b1);
    rec_cnt += (busy_recovery === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic bit in_set(logic [7:0] op, logic [7:0] s[]);
    foreach (s[i]) if (s[i] == op) return 1'b1;
    return 1'b0;
  endfunction

  // Latency-bound commands are only sent well before or well after the latency ends.
  function automatic bit predict(logic [7:0] op);
    if (cyc < m_rec) return 1'b0;
    if (!m_susp || in_set(op, nolat)) return 1'b1;
    if (in_set(op, lat)) return (cyc - m_st >= S_CYC);
    return 1'b0;
  endfunction

  function automatic void update(logic [7:0] op);
    if (op == OP_RESET_EXEC && m_arm) begin
      m_rec = cyc + (m_wip ? R_BUSY : R_IDLE) - REC_TAIL;
      exp_abt += m_wip;
      {m_wel, m_wip, m_susp, m_quad} = 4'h0;
    end
    if (op == OP_WR_ENABLE) m_wel = 1'b1;
    if (op == OP_WR_DISABLE) m_wel = 1'b0;
    if (op == OP_RESUME && m_susp && !enhance_mode) begin
      {m_wel, m_wip, m_susp} = 3'b110;
      exp_res++;
    end
    if (op == OP_ENTER_QUAD) m_quad = 1'b1;
    if (op == OP_EXIT_QUAD) m_quad = 1'b0;
    m_arm = (op == OP_RESET_ARM);
  endfunction

  task automatic cmd(input logic [7:0] op);
    int a0, r0;
    bit ok;
    logic [7:0] d;
    a0 = n_acc;
    r0 = n_rej;
    ok = predict(op);
    host.open_frame();
    host.shift(op, m_quad, d);
    host.close_frame();
    if (ok) update(op);
    check(n_acc - a0, ok);
    check(n_rej - r0, !ok);
    if (ok) check(cmd_code, op);
    check(flags, {m_wel, m_wip, m_susp, 1'b0});
    check(security_reg, {5'h00, m_susp, 2'b00});
    check(quad_command_mode, m_quad);
    check(n_res, exp_res);
    check(n_abt, exp_abt);
  endtask

  task automatic suspend();
    @(posedge ref_clk) suspend_done <= 1'b1;
    @(posedge ref_clk) suspend_done <= 1'b0;
    {m_susp, m_wel, m_wip} = 3'b100;
    m_st = cyc;
  endtask

  task automatic wait_rec(input int len);
    for (int n = 0; n < 2000 && busy_recovery !== 1'b0; n++) @(posedge ref_clk);
    check(rec_cnt >= len && rec_cnt <= len + 4, 1'b1);
    rec_cnt = 0;
  endtask

  task automatic param_read(input logic [7:0] a);
    logic [7:0] d;
    host.open_frame();
    host.shift(OP_PARAM_RD, 1'b0, d);
    repeat (2) host.shift(8'($urandom), 1'b0, d);
    host.shift(a, 1'b0, d);
    host.shift(8'($urandom), 1'b0, d);
    for (int i = 0; i < 3; i++) begin
      host.shift(8'hFF, 1'b0, d);
      check(d, 8'((a + 8'(i)) ^ 8'hC3));
    end
    check(sio_oe, 4'h2);
    host.close_frame();
    check(sio_oe, 4'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(81500));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(flags, 4'h0);
    check(busy_recovery, 1'b0);
    cmd(OP_NOP);
    cmd(OP_RESET_ARM);
    cmd(OP_NOP);
    cmd(OP_RESET_EXEC);
    check(busy_recovery, 1'b0);
    $display("test nop_disarm done");
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_EXEC);
    check(busy_recovery, 1'b1);
    cmd(OP_NOP);
    wait_rec(R_IDLE);
    $display("test reset_idle done");
    suspend();
    cmd(OP_READ);
    repeat (3) cmd(8'($urandom_range(8'h4F, 8'h40)));
    foreach (nolat[i]) cmd(nolat[i]);
    foreach (lat[i]) if (lat[i] != OP_RESUME && lat[i] != OP_ENTER_QUAD) cmd(lat[i]);
    $display("test suspend_set done");
    enhance_mode <= 1'b1;
    cmd(OP_RESUME);
    enhance_mode <= 1'b0;
    cmd(OP_RESUME);
    repeat (T_PROG) @(posedge ref_clk);
    check(flags.write_in_progress, 1'b1);
    @(posedge ref_clk) op_done <= 1'b1;
    @(posedge ref_clk) op_done <= 1'b0;
    {m_wel, m_wip} = 2'b00;
    repeat (2) @(posedge ref_clk);
    check(flags, 4'h0);
    $display("test resume done");
    suspend();
    repeat (S_CYC) @(posedge ref_clk);
    cmd(OP_RESUME);
    repeat (T_PROG) @(posedge ref_clk);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_EXEC);
    wait_rec(R_BUSY);
    $display("test reset_busy done");
    cmd(OP_ENTER_QUAD);
    cmd(OP_NOP);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_EXEC);
    wait_rec(R_IDLE);
    $display("test quad_reset done");
    param_read(8'hFE);
    $display("test param_read done");
    test_done();
  end

  // The whole sequence needs about 10000 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
